// [inc/tofcal_regs.vh]
// register offsets, fields, reset values and timing counts of the sampling and calibration bank
`ifndef TOFCAL_REGS_VH
`define TOFCAL_REGS_VH
`define TOFCAL_ADDR_PERIOD_COUNT 8'h11
`define TOFCAL_ADDR_PERIOD_MULT 8'h12
`define TOFCAL_ADDR_ACQ_CTRL 8'h13
`define TOFCAL_ADDR_GAIN_LIMITS 8'h19
`define TOFCAL_ADDR_I_EXP 8'h24
`define TOFCAL_ADDR_I_HIGH 8'h25
`define TOFCAL_ADDR_I_LOW 8'h26
`define TOFCAL_ADDR_Q_EXP 8'h27
`define TOFCAL_ADDR_Q_HIGH 8'h28
`define TOFCAL_ADDR_Q_LOW 8'h29
`define TOFCAL_ADDR_LGAIN_HIGH 8'h2a
`define TOFCAL_ADDR_LGAIN_LOW 8'h2b
`define TOFCAL_ADDR_AREF_EXP 8'h2c
`define TOFCAL_ADDR_AREF_HIGH 8'h2d
`define TOFCAL_ADDR_AREF_LOW 8'h2e
`define TOFCAL_ADDR_OFS_HIGH 8'h2f
`define TOFCAL_ADDR_OFS_LOW 8'h30
`define TOFCAL_ADDR_THERM_REF 8'h31
`define TOFCAL_ADDR_CORR_EXP 8'h33
`define TOFCAL_ADDR_THERM_LIN 8'h34
`define TOFCAL_ADDR_AMB_LIN 8'h36
`define TOFCAL_ADDR_THERM_SQ 8'h39
`define TOFCAL_ADDR_AMB_SQ 8'h3b
`define TOFCAL_ADDR_COMMAND 8'hb0
`define TOFCAL_CMD_SOFT_START 8'h49
`define TOFCAL_RST_PERIOD_COUNT 8'h00
`define TOFCAL_RST_PERIOD_MULT 8'h03
`define TOFCAL_RST_ACQ_CTRL 8'h7c
`define TOFCAL_RST_GAIN_LIMITS 8'h22
`define TOFCAL_RST_LGAIN_HIGH 8'hff
`define TOFCAL_RST_AREF_LOW 8'h01
`define TOFCAL_RST_ZERO 8'h00
`define TOFCAL_BIT_SINGLE_SHOT 0
`define TOFCAL_BIT_CAL_AFTER 1
`define TOFCAL_BIT_CAL_FREQ_LO 2
`define TOFCAL_BIT_CAL_FREQ_HI 3
`define TOFCAL_BIT_LIGHT_EN 4
`define TOFCAL_CAL_FREQ_BASE 8'h10
`define TOFCAL_BASE_PERIOD_NS 450000
`define TOFCAL_CLK_PERIOD_NS 25
`define TOFCAL_BASE_PERIOD_CYC (`TOFCAL_BASE_PERIOD_NS / `TOFCAL_CLK_PERIOD_NS)
`endif

// [logic/tofcal_regs.v]
// sampling and calibration register bank with acquisition sequencer
`timescale 1ns/10ps
`default_nettype none
`include "tofcal_regs.vh"

// Function
// - skip field multiplies period by power two
// - bit0 low: free running after one trigger
// - bit0 high: one measurement per trigger
// - bit1 orders single-shot calibration before or after light
// - free running: calibration every 16..128 samples
// - bit4 enables light and calibration sampling
// - gain loop floors from two 3-bit fields
// - in-phase leak exponent and split mantissa
// - quadrature leak exponent and split mantissa
// - 16-bit distance offset, zero at reset
// - 8-bit thermal reference point
// - one 4-bit exponent for all corrections
// - thermal quadratic, square and linear coefficients
// - ambient quadratic linear coefficient register
// - ambient quadratic square coefficient register
// - base interval 450us times count plus one
// - command 0x49 acts as software start
module tofcal_regs #(
	parameter BASE_CYCLES = `TOFCAL_BASE_PERIOD_CYC,
	parameter LIGHT_SAMPLES = 1
) (
	input wire clk_i,
	input wire reset_i,
	input wire wr_en_i,
	input wire rd_en_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	output reg [7:0] rdata_o,
	input wire trigger_i,
	output reg light_sample_o,
	output reg cal_sample_o,
	output reg busy_o,
	output reg [2:0] stage_one_gain_floor_o,
	output reg [2:0] stage_two_gain_floor_o,
	output reg [7:0] inphase_leak_exp_o,
	output reg [15:0] inphase_leak_o,
	output reg [7:0] quad_leak_exp_o,
	output reg [15:0] quad_leak_o,
	output reg [15:0] leak_gain_o,
	output reg [3:0] amplitude_ref_exp_o,
	output reg [15:0] amplitude_ref_o,
	output reg [15:0] distance_offset_o,
	output reg [7:0] thermal_reference_o,
	output reg [3:0] correction_exponent_o,
	output reg [7:0] thermal_linear_coeff_o,
	output reg [7:0] thermal_square_coeff_o,
	output reg [7:0] ambient_linear_coeff_o,
	output reg [7:0] ambient_square_coeff_o
);
	localparam ST_IDLE = 2'b00;
	localparam ST_WAIT = 2'b01;
	localparam ST_CAL_LAST = 2'b10;

	reg [7:0] period_count_q, period_mult_q, acq_ctrl_q, gain_limits_q;
	reg [7:0] i_exp_q, i_high_q, i_low_q;
	reg [7:0] q_exp_q, q_high_q, q_low_q;
	reg [7:0] lgain_high_q, lgain_low_q;
	reg [7:0] aref_exp_q, aref_high_q, aref_low_q;
	reg [7:0] ofs_high_q, ofs_low_q;
	reg [7:0] therm_ref_q, corr_exp_q, therm_lin_q, amb_lin_q, therm_sq_q, amb_sq_q;
	reg [2:0] trig_sync_q;
	reg [1:0] state_q;
	reg [19:0] base_cnt_q;
	reg [7:0] period_cnt_q;
	reg [3:0] skip_cnt_q;
	reg [7:0] light_cnt_q;
	reg [7:0] shot_cnt_q;
	reg running_q, trig_level_q;

	wire soft_start = wr_en_i && addr_i == `TOFCAL_ADDR_COMMAND && wdata_i == `TOFCAL_CMD_SOFT_START;
	// three-stage pin sync; a level counts once stages two and three agree, so one-cycle glitches drop out
	wire pin_start = trig_sync_q[1] && trig_sync_q[2] && !trig_level_q;
	wire start = soft_start || pin_start;
	wire single_shot = acq_ctrl_q[`TOFCAL_BIT_SINGLE_SHOT];
	wire cal_after = acq_ctrl_q[`TOFCAL_BIT_CAL_AFTER];
	wire sample_en = acq_ctrl_q[`TOFCAL_BIT_LIGHT_EN];
	wire [1:0] cal_freq = acq_ctrl_q[`TOFCAL_BIT_CAL_FREQ_HI:`TOFCAL_BIT_CAL_FREQ_LO];
	// 16 shifted by field gives 16..128
	wire [7:0] cal_every = `TOFCAL_CAL_FREQ_BASE << cal_freq;
	// multiplier is two to the skip field
	wire [3:0] skip_total = 4'h1 << period_mult_q[1:0];
	wire base_tick = base_cnt_q == BASE_CYCLES - 1;
	// base interval repeats count plus one times
	wire period_tick = base_tick && period_cnt_q == period_count_q;
	wire interval_tick = period_tick && skip_cnt_q == skip_total - 4'h1;

	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			period_count_q <= `TOFCAL_RST_PERIOD_COUNT;
			period_mult_q <= `TOFCAL_RST_PERIOD_MULT;
			acq_ctrl_q <= `TOFCAL_RST_ACQ_CTRL;
			gain_limits_q <= `TOFCAL_RST_GAIN_LIMITS;
			i_exp_q <= `TOFCAL_RST_ZERO;
			i_high_q <= `TOFCAL_RST_ZERO;
			i_low_q <= `TOFCAL_RST_ZERO;
			q_exp_q <= `TOFCAL_RST_ZERO;
			q_high_q <= `TOFCAL_RST_ZERO;
			q_low_q <= `TOFCAL_RST_ZERO;
			lgain_high_q <= `TOFCAL_RST_LGAIN_HIGH;
			lgain_low_q <= `TOFCAL_RST_ZERO;
			aref_exp_q <= `TOFCAL_RST_ZERO;
			aref_high_q <= `TOFCAL_RST_ZERO;
			aref_low_q <= `TOFCAL_RST_AREF_LOW;
			ofs_high_q <= `TOFCAL_RST_ZERO;
			ofs_low_q <= `TOFCAL_RST_ZERO;
			therm_ref_q <= `TOFCAL_RST_ZERO;
			corr_exp_q <= `TOFCAL_RST_ZERO;
			therm_lin_q <= `TOFCAL_RST_ZERO;
			amb_lin_q <= `TOFCAL_RST_ZERO;
			therm_sq_q <= `TOFCAL_RST_ZERO;
			amb_sq_q <= `TOFCAL_RST_ZERO;
		end
		else if (wr_en_i)
		begin
			case (addr_i)
				`TOFCAL_ADDR_PERIOD_COUNT: period_count_q <= wdata_i;
				`TOFCAL_ADDR_PERIOD_MULT: period_mult_q <= wdata_i;
				`TOFCAL_ADDR_ACQ_CTRL: acq_ctrl_q <= wdata_i;
				`TOFCAL_ADDR_GAIN_LIMITS: gain_limits_q <= wdata_i;
				`TOFCAL_ADDR_I_EXP: i_exp_q <= wdata_i;
				`TOFCAL_ADDR_I_HIGH: i_high_q <= wdata_i;
				`TOFCAL_ADDR_I_LOW: i_low_q <= wdata_i;
				`TOFCAL_ADDR_Q_EXP: q_exp_q <= wdata_i;
				`TOFCAL_ADDR_Q_HIGH: q_high_q <= wdata_i;
				`TOFCAL_ADDR_Q_LOW: q_low_q <= wdata_i;
				`TOFCAL_ADDR_LGAIN_HIGH: lgain_high_q <= wdata_i;
				`TOFCAL_ADDR_LGAIN_LOW: lgain_low_q <= wdata_i;
				`TOFCAL_ADDR_AREF_EXP: aref_exp_q <= wdata_i;
				`TOFCAL_ADDR_AREF_HIGH: aref_high_q <= wdata_i;
				`TOFCAL_ADDR_AREF_LOW: aref_low_q <= wdata_i;
				`TOFCAL_ADDR_OFS_HIGH: ofs_high_q <= wdata_i;
				`TOFCAL_ADDR_OFS_LOW: ofs_low_q <= wdata_i;
				`TOFCAL_ADDR_THERM_REF: therm_ref_q <= wdata_i;
				`TOFCAL_ADDR_CORR_EXP: corr_exp_q <= wdata_i;
				`TOFCAL_ADDR_THERM_LIN: therm_lin_q <= wdata_i;
				`TOFCAL_ADDR_AMB_LIN: amb_lin_q <= wdata_i;
				`TOFCAL_ADDR_THERM_SQ: therm_sq_q <= wdata_i;
				`TOFCAL_ADDR_AMB_SQ: amb_sq_q <= wdata_i;
				default: ;
			endcase
		end
	end

	// unmapped and command addresses read back as zero
	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			rdata_o <= 8'h00;
		end
		else if (rd_en_i)
		begin
			case (addr_i)
				`TOFCAL_ADDR_PERIOD_COUNT: rdata_o <= period_count_q;
				`TOFCAL_ADDR_PERIOD_MULT: rdata_o <= period_mult_q;
				`TOFCAL_ADDR_ACQ_CTRL: rdata_o <= acq_ctrl_q;
				`TOFCAL_ADDR_GAIN_LIMITS: rdata_o <= gain_limits_q;
				`TOFCAL_ADDR_I_EXP: rdata_o <= i_exp_q;
				`TOFCAL_ADDR_I_HIGH: rdata_o <= i_high_q;
				`TOFCAL_ADDR_I_LOW: rdata_o <= i_low_q;
				`TOFCAL_ADDR_Q_EXP: rdata_o <= q_exp_q;
				`TOFCAL_ADDR_Q_HIGH: rdata_o <= q_high_q;
				`TOFCAL_ADDR_Q_LOW: rdata_o <= q_low_q;
				`TOFCAL_ADDR_LGAIN_HIGH: rdata_o <= lgain_high_q;
				`TOFCAL_ADDR_LGAIN_LOW: rdata_o <= lgain_low_q;
				`TOFCAL_ADDR_AREF_EXP: rdata_o <= aref_exp_q;
				`TOFCAL_ADDR_AREF_HIGH: rdata_o <= aref_high_q;
				`TOFCAL_ADDR_AREF_LOW: rdata_o <= aref_low_q;
				`TOFCAL_ADDR_OFS_HIGH: rdata_o <= ofs_high_q;
				`TOFCAL_ADDR_OFS_LOW: rdata_o <= ofs_low_q;
				`TOFCAL_ADDR_THERM_REF: rdata_o <= therm_ref_q;
				`TOFCAL_ADDR_CORR_EXP: rdata_o <= corr_exp_q;
				`TOFCAL_ADDR_THERM_LIN: rdata_o <= therm_lin_q;
				`TOFCAL_ADDR_AMB_LIN: rdata_o <= amb_lin_q;
				`TOFCAL_ADDR_THERM_SQ: rdata_o <= therm_sq_q;
				`TOFCAL_ADDR_AMB_SQ: rdata_o <= amb_sq_q;
				default: rdata_o <= 8'h00;
			endcase
		end
	end

	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			stage_one_gain_floor_o <= 3'h0;
			stage_two_gain_floor_o <= 3'h0;
			inphase_leak_exp_o <= 8'h00;
			inphase_leak_o <= 16'h0000;
			quad_leak_exp_o <= 8'h00;
			quad_leak_o <= 16'h0000;
			leak_gain_o <= 16'h0000;
			amplitude_ref_exp_o <= 4'h0;
			amplitude_ref_o <= 16'h0000;
			distance_offset_o <= 16'h0000;
			thermal_reference_o <= 8'h00;
			correction_exponent_o <= 4'h0;
			thermal_linear_coeff_o <= 8'h00;
			thermal_square_coeff_o <= 8'h00;
			ambient_linear_coeff_o <= 8'h00;
			ambient_square_coeff_o <= 8'h00;
		end
		else
		begin
			// floors taken from fields 2:0 and 6:4
			stage_one_gain_floor_o <= gain_limits_q[2:0];
			stage_two_gain_floor_o <= gain_limits_q[6:4];
			inphase_leak_exp_o <= i_exp_q;
			inphase_leak_o <= {i_high_q, i_low_q};
			quad_leak_exp_o <= q_exp_q;
			quad_leak_o <= {q_high_q, q_low_q};
			leak_gain_o <= {lgain_high_q, lgain_low_q};
			amplitude_ref_exp_o <= aref_exp_q[3:0];
			amplitude_ref_o <= {aref_high_q, aref_low_q};
			distance_offset_o <= {ofs_high_q, ofs_low_q};
			thermal_reference_o <= therm_ref_q;
			correction_exponent_o <= corr_exp_q[3:0];
			thermal_linear_coeff_o <= therm_lin_q;
			thermal_square_coeff_o <= therm_sq_q;
			ambient_linear_coeff_o <= amb_lin_q;
			ambient_square_coeff_o <= amb_sq_q;
		end
	end

	// sequencer: one light or calibration sample pulse per interval
	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_q <= ST_IDLE;
			running_q <= 1'b0;
			base_cnt_q <= 20'h00000;
			period_cnt_q <= 8'h00;
			skip_cnt_q <= 4'h0;
			light_cnt_q <= 8'h00;
			shot_cnt_q <= 8'h00;
			light_sample_o <= 1'b0;
			cal_sample_o <= 1'b0;
			busy_o <= 1'b0;
			trig_sync_q <= 3'h0;
			trig_level_q <= 1'b0;
		end
		else
		begin
			trig_sync_q <= {trig_sync_q[1:0], trigger_i};
			trig_level_q <= (trig_sync_q[1] == trig_sync_q[2]) ? trig_sync_q[2] : trig_level_q;
			light_sample_o <= 1'b0;
			cal_sample_o <= 1'b0;
			if (running_q)
			begin
				base_cnt_q <= base_tick ? 20'h00000 : base_cnt_q + 20'h00001;
				if (base_tick)
				begin
					period_cnt_q <= period_tick ? 8'h00 : period_cnt_q + 8'h01;
				end
				if (period_tick)
				begin
					skip_cnt_q <= interval_tick ? 4'h0 : skip_cnt_q + 4'h1;
				end
			end
			case (state_q)
				ST_IDLE:
				begin
					// sampling disabled holds the sequencer idle
					if (start && sample_en)
					begin
						running_q <= 1'b1;
						busy_o <= 1'b1;
						base_cnt_q <= 20'h00000;
						period_cnt_q <= 8'h00;
						skip_cnt_q <= 4'h0;
						light_cnt_q <= 8'h00;
						shot_cnt_q <= 8'h00;
						// calibration first when single shot and order bit is low
						if (single_shot && !cal_after)
						begin
							cal_sample_o <= 1'b1;
						end
						else
						begin
							light_sample_o <= 1'b1;
							light_cnt_q <= 8'h01;
							shot_cnt_q <= 8'h01;
						end
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT:
				begin
					if (!sample_en)
					begin
						running_q <= 1'b0;
						busy_o <= 1'b0;
						state_q <= ST_IDLE;
					end
					else if (interval_tick)
					begin
						if (single_shot)
						begin
							// single shot ends after its samples
							if (shot_cnt_q < LIGHT_SAMPLES)
							begin
								light_sample_o <= 1'b1;
								shot_cnt_q <= shot_cnt_q + 8'h01;
							end
							else if (cal_after)
							begin
								cal_sample_o <= 1'b1;
								state_q <= ST_CAL_LAST;
							end
							else
							begin
								running_q <= 1'b0;
								busy_o <= 1'b0;
								state_q <= ST_IDLE;
							end
						end
						else if (light_cnt_q == cal_every)
						begin
							cal_sample_o <= 1'b1;
							light_cnt_q <= 8'h00;
						end
						else
						begin
							// free running needs no further trigger
							light_sample_o <= 1'b1;
							light_cnt_q <= light_cnt_q + 8'h01;
						end
					end
				end
				ST_CAL_LAST:
				begin
					running_q <= 1'b0;
					busy_o <= 1'b0;
					state_q <= ST_IDLE;
				end
				default:
				begin
					running_q <= 1'b0;
					busy_o <= 1'b0;
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// [test/tofcal_regs_properties.sv]
// port assertions of the sampling and calibration bank
`timescale 1ns/10ps
`default_nettype none
module tofcal_regs_properties #(
	parameter BASE_CYCLES = 4,
	parameter LIGHT_SAMPLES = 1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic wr_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic light_sample_o,
	input wire logic cal_sample_o,
	input wire logic busy_o,
	input wire logic [2:0] stage_one_gain_floor_o,
	input wire logic [2:0] stage_two_gain_floor_o,
	input wire logic [15:0] distance_offset_o,
	input wire logic [3:0] correction_exponent_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire smp = light_sample_o | cal_sample_o;
	AST_FLOOR_ONE: assert property (wr_en_i && addr_i == 8'h19
		|-> ##2 stage_one_gain_floor_o == $past(wdata_i[2:0], 2)) else $error("floor one wrong");
	AST_FLOOR_TWO: assert property (wr_en_i && addr_i == 8'h19
		|-> ##2 stage_two_gain_floor_o == $past(wdata_i[6:4], 2)) else $error("floor two wrong");
	AST_OFS_LOW: assert property (wr_en_i && addr_i == 8'h30
		|-> ##2 distance_offset_o[7:0] == $past(wdata_i, 2)) else $error("offset low wrong");
	AST_CORR_EXP: assert property (wr_en_i && addr_i == 8'h33
		|-> ##2 correction_exponent_o == $past(wdata_i[3:0], 2)) else $error("exponent wrong");
	AST_EXCL: assert property (!(light_sample_o && cal_sample_o)) else $error("two samples at once");
	AST_BUSY: assert property (smp |-> busy_o) else $error("sample while idle");
	AST_SPACING: assert property (smp |=> !smp [*3]) else $error("samples too close");
	AST_STOP: assert property (wr_en_i && addr_i == 8'h13 && !wdata_i[4]
		|-> ##[1:3] !busy_o) else $error("disable did not stop");
	cover property (cal_sample_o);
	cover property (light_sample_o ##4 light_sample_o);
	cover property (busy_o ##1 !busy_o);
endmodule
bind tofcal_regs tofcal_regs_properties #(.BASE_CYCLES(BASE_CYCLES), .LIGHT_SAMPLES(LIGHT_SAMPLES)) u_props (
	.clk_i(clk_i), .reset_i(reset_i), .wr_en_i(wr_en_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.light_sample_o(light_sample_o), .cal_sample_o(cal_sample_o), .busy_o(busy_o),
	.stage_one_gain_floor_o(stage_one_gain_floor_o), .stage_two_gain_floor_o(stage_two_gain_floor_o),
	.distance_offset_o(distance_offset_o), .correction_exponent_o(correction_exponent_o)
);
`default_nettype wire

// [test/tofcal_host.sv]
// host model: register strobes and start pin toward the bank
`timescale 1ns/10ps
`default_nettype none
module tofcal_host (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic wr_en_o,
	output logic rd_en_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	output logic trigger_o
);
	initial
	begin
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
		trigger_o = 1'b0;
	end
	// write data and read address show the inverse on release so stale data never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_en_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_en_o <= 1'b0;
		wdata_o <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_en_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_en_o <= 1'b0;
		addr_o <= ~a;
		#1;
		d = rdata_i;
	endtask
	task automatic start();
		wr(8'hb0, 8'h49);
	endtask
	task automatic trig(input logic v);
		@(posedge clk_i);
		trigger_o <= v;
	endtask
endmodule
`default_nettype wire

// [test/tofcal_regs_tb.sv]
// self-checking bench of the sampling and calibration bank
`timescale 1ns/10ps
`default_nettype none
module tofcal_regs_tb;
	localparam int BASE = 4;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	wire wr_en, rd_en, trig, ls, cs, busy;
	wire [7:0] addr, wdata, rdata, ie, qe, tr, tl, ts, al, as;
	wire [2:0] f1, f2;
	wire [15:0] il, ql, lg, ar, dofs;
	wire [3:0] ae, ce;
	int bad_count = 0;
	int comparisons = 0;
	logic [7:0] ra [0:22] = '{8'h11, 8'h12, 8'h13, 8'h19, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b,
		8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h33, 8'h34, 8'h36, 8'h39, 8'h3b};
	logic [7:0] rv [0:22] = '{8'h00, 8'h03, 8'h7c, 8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
		8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	always #12.5 clk_i = ~clk_i;
	tofcal_host host (.clk_i(clk_i), .rdata_i(rdata), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
		.wdata_o(wdata), .trigger_o(trig));
	tofcal_regs #(.BASE_CYCLES(BASE), .LIGHT_SAMPLES(1)) DUT (.clk_i(clk_i), .reset_i(reset_i),
		.wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .trigger_i(trig),
		.light_sample_o(ls), .cal_sample_o(cs), .busy_o(busy), .stage_one_gain_floor_o(f1),
		.stage_two_gain_floor_o(f2), .inphase_leak_exp_o(ie), .inphase_leak_o(il), .quad_leak_exp_o(qe),
		.quad_leak_o(ql), .leak_gain_o(lg), .amplitude_ref_exp_o(ae), .amplitude_ref_o(ar),
		.distance_offset_o(dofs), .thermal_reference_o(tr), .correction_exponent_o(ce),
		.thermal_linear_coeff_o(tl), .thermal_square_coeff_o(ts), .ambient_linear_coeff_o(al),
		.ambient_square_coeff_o(as));
	function automatic logic [7:0] x(input logic [7:0] a);
		return a ^ 8'ha5;
	endfunction
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_smp(output logic c, output int g);
		g = 0;
		do
		begin
			@(posedge clk_i);
			#1;
			g++;
		end while (!(ls | cs) && g < 300);
		c = cs;
		if (g >= 300)
		begin
			bad_count++;
			summarize();
		end
	endtask
	task automatic idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 40)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (busy !== 1'b0)
		begin
			bad_count++;
			summarize();
		end
	endtask
	task automatic t_reset();
		logic [7:0] d;
		for (int i = 0; i < 23; i++)
		begin
			host.rd(ra[i], d);
			chk(d, rv[i]);
		end
		chk(f1, 3'h2);
		chk(f2, 3'h2);
		chk(dofs, 16'h0000);
		chk(lg, 16'hff00);
		chk(ar, 16'h0001);
		$display("reset test done");
	endtask
	task automatic t_rw();
		logic [7:0] d;
		for (int i = 3; i < 23; i++)
			host.wr(ra[i], x(ra[i]));
		for (int i = 3; i < 23; i++)
		begin
			host.rd(ra[i], d);
			chk(d, x(ra[i]));
		end
		chk(il, {x(8'h25), x(8'h26)});
		chk(ie, x(8'h24));
		chk(ql, {x(8'h28), x(8'h29)});
		chk(qe, x(8'h27));
		chk(dofs, {x(8'h2f), x(8'h30)});
		chk(tr, x(8'h31));
		chk(ce, x(8'h33) & 8'h0f);
		chk({ts, tl}, {x(8'h39), x(8'h34)});
		chk(al, x(8'h36));
		chk(as, x(8'h3b));
		chk({f2, f1}, ((x(8'h19) >> 1) & 8'h38) | (x(8'h19) & 8'h07));
		chk(lg, {x(8'h2a), x(8'h2b)});
		chk(ar, {x(8'h2d), x(8'h2e)});
		chk(ae, x(8'h2c) & 8'h0f);
		host.wr(8'h20, 8'h77);
		host.rd(8'h20, d);
		chk(d, 8'h00);
		$display("register test done");
	endtask
	// first pulse stands right after the start edge, so it is judged before waiting
	task automatic free_run(input int n, input int gap);
		logic c;
		int g;
		host.start();
		#1;
		chk({busy, cs, ls}, 3'h5);
		for (int i = 1; i <= n; i++)
		begin
			wait_smp(c, g);
			chk(c, i == n);
			chk(g, gap);
		end
		chk(busy, 1'b1);
		host.wr(8'h13, 8'h00);
		idle();
	endtask
	task automatic t_free();
		logic c;
		int g;
		host.wr(8'h13, 8'h10);
		free_run(16, BASE * 8);
		host.wr(8'h11, 8'h01);
		host.wr(8'h12, 8'h02);
		host.start();
		repeat (20) @(posedge clk_i);
		#1;
		chk(busy, 1'b0);
		host.wr(8'h13, 8'h10);
		host.start();
		wait_smp(c, g);
		wait_smp(c, g);
		chk(g, BASE * 2 * 4);
		host.wr(8'h13, 8'h00);
		idle();
		host.wr(8'h11, 8'h00);
		host.wr(8'h12, 8'h00);
		for (int f = 1; f < 4; f++)
		begin
			host.wr(8'h13, {4'h1, f[1:0], 2'h0});
			free_run(16 << f, BASE);
		end
		$display("free running test done");
	endtask
	task automatic t_single();
		logic c;
		int g;
		host.wr(8'h11, 8'h00);
		host.wr(8'h12, 8'h00);
		for (int k = 0; k < 2; k++)
		begin
			host.wr(8'h13, k ? 8'h13 : 8'h11);
			host.trig(1'b1);
			wait_smp(c, g);
			chk(c, k == 0);
			wait_smp(c, g);
			chk(c, k == 1);
			chk(g, BASE);
			host.trig(1'b0);
			idle();
		end
		$display("single shot test done");
	endtask
	initial
	begin
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset();
		t_rw();
		t_free();
		t_single();
		summarize();
	end
endmodule
`default_nettype wire
